// ---- shared/gpio_port_one_consts.svh ----
// Register offsets, reset values and bus codes of the eight-bit port
`ifndef GPIO_PORT_ONE_CONSTS_SVH
`define GPIO_PORT_ONE_CONSTS_SVH

// Byte offsets within the 16-byte register window
`define OFS_DATA 4'h0
`define OFS_DIR 4'h4
`define OFS_PULLUP 4'h8
`define OFS_LATCH_VIEW 4'hC

// Decoded offset width and the port width in pins
`define OFS_BITS 4
`define PORT_BITS 8

// Reset values of the three registers
`define RST_LATCH 8'h00
`define RST_DIR 8'h00
`define RST_PULLUP 8'h00

// Fill for the unused upper bits of a read word
`define READ_PAD 24'h000000

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Lines whose inputs may stay open in forced standby
`define IRQ_LINE_A 0
`define IRQ_LINE_B 4

`endif

// ---- shared/gpio_port_one_pkg.sv ----
// Types shared by the port, the board model and the bench
package gpio_port_one_pkg;

    // Drive onto the eight pads, from the port or from a peripheral
    typedef struct packed {
        logic [7:0] oe;
        logic [7:0] out;
    } pad_drive_t;

    // State handed over by the standby controller
    typedef struct packed {
        logic pin_state_select;
        logic stop_or_watch;
    } standby_t;

    // Interrupt qualifiers for the two exempt lines (index 0: line 0, index 1: line 4)
    typedef struct packed {
        logic [1:0] ext_ctrl_en;
        logic [1:0] pin_sel_en;
    } irq_qual_t;

endpackage : gpio_port_one_pkg

// ---- logic/gpio_pin_cell.sv ----
// One port pin: output mux, pull-up gating and synchronised input path
`timescale 1ns/10ps
module gpio_pin_cell #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bits for this pin
    input wire logic latch_bit,
    input wire logic dir_bit,
    input wire logic pullup_bit,
    // Shared peripheral drive
    input wire logic periph_oe,
    input wire logic periph_out,
    // Standby control
    input wire logic forced_hiz,
    input wire logic input_exempt,
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic pullup_on,
    // Synchronised, possibly blocked, input level
    output logic in_gated_r
);

    logic drive_val; // Level wanted on the pad
    logic drive_en; // Pad is actively driven
    logic sync1_r; // First synchroniser stage, read only by sync2_r
    logic sync2_r; // Second synchroniser stage
    logic block; // Input path held low

    // Peripheral drive takes the pin over from the port latch
    always_comb begin
        drive_val = periph_oe ? periph_out : latch_bit;
        drive_en = (periph_oe | dir_bit) & ~forced_hiz;
    end

    // An open-drain pad never drives high, a latched 1 leaves it floating
    assign pad_oe = OPEN_DRAIN ? (drive_en & ~drive_val) : drive_en;
    assign pad_out = OPEN_DRAIN ? 1'b0 : drive_val;

    // Pull-up is cut whenever the pad is pulled low, to stop a static current
    assign pullup_on = pullup_bit & ~(pad_oe & ~pad_out);

    // Blocking applies only in forced standby, interrupt lines may be exempt
    assign block = forced_hiz & ~input_exempt;

    // Two-stage synchroniser, then the blocking gate in a third flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            in_gated_r <= 1'b0;
        end else begin
            sync1_r <= pad_in;
            sync2_r <= sync1_r;
            in_gated_r <= sync2_r & ~block;
        end
    end

endmodule : gpio_pin_cell

// ---- logic/gpio_port_one.sv ----
// Eight-bit general-purpose port with AXI4-Lite register access
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`include "gpio_port_one_consts.svh"

// What this block does
// - direction bit 1 output, 0 input, per pin
// - output pin drives its latch bit
// - data write with the byte lane 0 strobe set always updates latch
// - output pin reads back latch value
// - input pin reads back sampled pin level
// - read-modify-write read returns latch always
// - peripheral drives pin, read shows pin
// - peripheral input pin still readable
// - reset clears every direction bit
// - forced standby floats every pin
// - forced standby blocks inputs, held low
// - enabled interrupt lines 0, 4 stay open
// - unforced standby keeps all pin states
// - pull-up bit connects the pull-up
// - low output always cuts the pull-up
// - open-drain latched 1 floats the pin
// - register bit n maps to pin n
module gpio_port_one
    import gpio_port_one_pkg::*;
#(
    parameter int PORT_W = 8,
    parameter int ADDR_W = 12,
    parameter logic [7:0] OPEN_DRAIN_MASK = 8'h00
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Standby controller and interrupt qualifiers
    input wire standby_t standby,
    input wire irq_qual_t irq_qual,
    // Shared peripherals
    input wire pad_drive_t periph,
    output logic [7:0] periph_in,
    // Pads
    input wire logic [7:0] pad_in,
    output pad_drive_t pad,
    output logic [7:0] pullup_on
);

    // The register map and the package types are fixed at eight pins
    if (PORT_W != `PORT_BITS) begin : g_bad_width
        $error("PORT_W must be 8");
    end
    if (ADDR_W < `OFS_BITS + 1) begin : g_bad_addr
        $error("ADDR_W too small for the register window");
    end

    // Software-visible registers, bit n belongs to pin n
    logic [7:0] latch_r; // Output latch
    logic [7:0] dir_r; // Direction, 1 is output
    logic [7:0] pul_r; // Pull-up select

    // Pin-side state
    logic forced_hiz; // Standby with pins forced to float
    logic [7:0] input_exempt; // Lines whose input stays open in standby
    logic [7:0] in_gated; // Synchronised and gated pad levels
    logic [7:0] read_mix; // Value an ordinary data read returns

    // Write channel state
    logic aw_held_r; // Address taken, waiting for data
    logic [ADDR_W-1:0] aw_addr_r; // Held write address
    logic w_held_r; // Data taken, waiting for address
    logic [31:0] w_data_r; // Held write data
    logic [3:0] w_strb_r; // Held byte strobes
    logic bvalid_r; // Response pending
    logic [1:0] bresp_r; // Response code

    // Read channel state
    logic rvalid_r; // Read data pending
    logic [31:0] rdata_r; // Read word
    logic [1:0] rresp_r; // Read response code

    // Combined write request
    logic aw_hs; // Address handshake this cycle
    logic w_hs; // Data handshake this cycle
    logic wr_fire; // Both halves present, perform the write
    logic [ADDR_W-1:0] wr_addr; // Address of the write
    logic [31:0] wr_data; // Data of the write
    logic [3:0] wr_strb; // Strobes of the write
    logic wr_mapped; // Upper address bits are zero
    logic ar_hs; // Read address handshake
    logic rd_mapped; // Upper read address bits are zero

    // Standby controller state is on this clock, so no synchroniser
    assign forced_hiz = standby.pin_state_select & standby.stop_or_watch;

    // Only lines 0 and 4 may be exempt, and only with both enables set
    always_comb begin
        input_exempt = 8'h00;
        input_exempt[`IRQ_LINE_A] = irq_qual.ext_ctrl_en[0] & irq_qual.pin_sel_en[0];
        input_exempt[`IRQ_LINE_B] = irq_qual.ext_ctrl_en[1] & irq_qual.pin_sel_en[1];
    end

    // One cell per pin, bit n of every register goes to cell n
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        gpio_pin_cell #(
            .OPEN_DRAIN(OPEN_DRAIN_MASK[i])
        ) u_cell (
            .aclk(aclk),
            .aresetn(aresetn),
            .latch_bit(latch_r[i]),
            .dir_bit(dir_r[i]),
            .pullup_bit(pul_r[i]),
            .periph_oe(periph.oe[i]),
            .periph_out(periph.out[i]),
            .forced_hiz(forced_hiz),
            .input_exempt(input_exempt[i]),
            .pad_in(pad_in[i]),
            .pad_out(pad.out[i]),
            .pad_oe(pad.oe[i]),
            .pullup_on(pullup_on[i]),
            .in_gated_r(in_gated[i])
        );
    end

    // Peripheral inputs see the pin whether or not the port uses it
    assign periph_in = in_gated;

    // Port output pins read the latch, everything else reads the pin
    // A peripheral-driven pin reads the pad, so its output can be observed
    assign read_mix = (dir_r & ~periph.oe & latch_r) | (~(dir_r & ~periph.oe) & in_gated);

    // Handshakes; a new address or data half is refused while a response waits
    assign awready = ~aw_held_r & ~bvalid_r;
    assign wready = ~w_held_r & ~bvalid_r;
    assign aw_hs = awvalid & awready;
    assign w_hs = wvalid & wready;
    assign wr_fire = (aw_held_r | aw_hs) & (w_held_r | w_hs);
    assign wr_addr = aw_held_r ? aw_addr_r : awaddr;
    assign wr_data = w_held_r ? w_data_r : wdata;
    assign wr_strb = w_held_r ? w_strb_r : wstrb;
    assign wr_mapped = (wr_addr[ADDR_W-1:`OFS_BITS] == '0);
    assign arready = ~rvalid_r;
    assign ar_hs = arvalid & arready;
    assign rd_mapped = (araddr[ADDR_W-1:`OFS_BITS] == '0);

    // Address half waits here until its data arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (aw_hs) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= awaddr;
        end
    end

    // Data half waits here until its address arrives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (w_hs) begin
            w_held_r <= 1'b1;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
        end
    end

    // Register writes; only byte lane 0 carries register bits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_r <= `RST_LATCH;
            dir_r <= `RST_DIR;
            pul_r <= `RST_PULLUP;
        end else if (wr_fire && wr_mapped && wr_strb[0]) begin
            case (wr_addr[`OFS_BITS-1:0])
                `OFS_DATA: begin
                    // Stored whatever the direction, shown only on output pins
                    latch_r <= wr_data[7:0];
                end
                `OFS_DIR: begin
                    dir_r <= wr_data[7:0];
                end
                `OFS_PULLUP: begin
                    pul_r <= wr_data[7:0];
                end
                default: begin
                    // Latch view is read-only, unmapped offsets store nothing
                end
            endcase
        end
    end

    // Write response, held until the master takes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            if (wr_mapped && (wr_addr[`OFS_BITS-1:0] == `OFS_DATA || wr_addr[`OFS_BITS-1:0] == `OFS_DIR ||
                              wr_addr[`OFS_BITS-1:0] == `OFS_PULLUP)) begin
                bresp_r <= `RESP_OKAY;
            end else begin
                bresp_r <= `RESP_SLVERR;
            end
        end else if (bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read path; the latch view serves read-modify-write sequences
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= `RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rresp_r <= `RESP_OKAY;
            if (!rd_mapped) begin
                rdata_r <= 32'h00000000;
                rresp_r <= `RESP_SLVERR;
            end else begin
                case (araddr[`OFS_BITS-1:0])
                    `OFS_DATA: begin
                        rdata_r <= {`READ_PAD, read_mix};
                    end
                    `OFS_DIR: begin
                        rdata_r <= {`READ_PAD, dir_r};
                    end
                    `OFS_PULLUP: begin
                        rdata_r <= {`READ_PAD, pul_r};
                    end
                    `OFS_LATCH_VIEW: begin
                        // Latch in every pin mode, so modify-write keeps unrelated bits
                        rdata_r <= {`READ_PAD, latch_r};
                    end
                    default: begin
                        rdata_r <= 32'h00000000;
                        rresp_r <= `RESP_SLVERR;
                    end
                endcase
            end
        end else if (rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Bus outputs straight from flops
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;

    // Checks on this clock domain
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Write steps: request taken, then response pending until accepted
    sequence s_write_taken;
        wr_fire;
    endsequence
    sequence s_resp_waits;
        bvalid_r && !bready;
    endsequence

    a_write_resp_next: assert property (s_write_taken |=> bvalid_r ##0 !awready ##0 !wready)
        else $error("write response not raised after write");
    a_write_resp_holds: assert property (s_resp_waits |=> bvalid_r && $stable(bresp_r))
        else $error("write response dropped before acceptance");

    a_dir_reset_clear: assert property (disable iff (1'b0) !aresetn |=> dir_r == `RST_DIR)
        else $error("direction not cleared by reset");

    a_latch_write_store: assert property (
        wr_fire && wr_mapped && wr_strb[0] && wr_addr[`OFS_BITS-1:0] == `OFS_DATA
        |=> latch_r == $past(wr_data[7:0]))
        else $error("data write did not update latch");

    a_port_drives_pin: assert property (
        !forced_hiz |-> ((dir_r | periph.oe) & ~OPEN_DRAIN_MASK) == (pad.oe & ~OPEN_DRAIN_MASK))
        else $error("pad enable does not follow direction");

    a_output_latch_level: assert property (
        ((pad.oe & dir_r & ~periph.oe & ~OPEN_DRAIN_MASK) & (pad.out ^ latch_r)) == 8'h00)
        else $error("output pin level differs from latch");

    a_rmw_view_latch: assert property (
        ar_hs && rd_mapped && araddr[`OFS_BITS-1:0] == `OFS_LATCH_VIEW
        |=> rvalid_r && rdata_r[7:0] == $past(latch_r) && rresp_r == `RESP_OKAY)
        else $error("latch view read wrong");

    a_data_read_input: assert property (
        ar_hs && rd_mapped && araddr[`OFS_BITS-1:0] == `OFS_DATA && dir_r == 8'h00
        |=> rdata_r[7:0] == $past(in_gated))
        else $error("input pin read wrong");

    a_forced_float: assert property (forced_hiz |-> pad.oe == 8'h00)
        else $error("pad driven in forced standby");

    a_input_blocked: assert property (
        $past(forced_hiz) |-> (in_gated & ~$past(input_exempt)) == 8'h00)
        else $error("blocked input not held low");

    a_standby_keeps: assert property (
        !forced_hiz && standby.stop_or_watch && $past(!forced_hiz) && $stable(dir_r) && $stable(latch_r)
        && $stable(periph) |-> $stable(pad))
        else $error("unforced standby changed pins");

    a_pullup_cut_low: assert property ((pullup_on & pad.oe & ~pad.out) == 8'h00)
        else $error("pull-up on a low output");

    a_pullup_select: assert property (
        ((~pad.oe | pad.out) & (pullup_on ^ pul_r)) == 8'h00)
        else $error("pull-up does not follow select");

    a_od_no_high: assert property ((pad.oe & pad.out & OPEN_DRAIN_MASK) == 8'h00)
        else $error("open-drain pin driven high");

endmodule : gpio_port_one

// ---- bench/pad_board_model.sv ----
// Board side of the eight pads: external drivers, pull-ups and floating lines
`timescale 1ns/10ps
module pad_board_model
    import gpio_port_one_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Port drive and pull-ups
    input wire pad_drive_t pad,
    input wire logic [7:0] pullup_on,
    // Board drivers
    input wire logic [7:0] ext_oe,
    input wire logic [7:0] ext_val,
    // Resolved pad levels
    output logic [7:0] level
);
    // Undriven pads wander every cycle, so no stale value passes by luck
    logic [7:0] float_r = 8'h55;

    // Floating pattern
    always @(posedge aclk) begin
        float_r <= ~float_r;
    end

    // Port drive wins over the board; pull-up only where nobody drives
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pad.oe[i]) begin
                level[i] = pad.out[i];
            end else if (ext_oe[i]) begin
                level[i] = ext_val[i];
            end else if (pullup_on[i]) begin
                level[i] = 1'b1;
            end else begin
                level[i] = float_r[i];
            end
        end
    end
endmodule : pad_board_model

// ---- bench/eight_bit_gpio_port_one_bench.sv ----
// Self-checking bench for the eight-bit port
`timescale 1ns/10ps
`include "gpio_port_one_consts.svh"
module eight_bit_gpio_port_one_bench
    import gpio_port_one_pkg::*;
();
    // Register addresses; A_BAD has upper bits set
    localparam logic [11:0] A_DAT = {8'h00, `OFS_DATA};
    localparam logic [11:0] A_DIR = {8'h00, `OFS_DIR};
    localparam logic [11:0] A_PUL = {8'h00, `OFS_PULLUP};
    localparam logic [11:0] A_VIEW = {8'h00, `OFS_LATCH_VIEW};
    localparam logic [11:0] A_BAD = 12'h010;
    // Bus and pin stimulus
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    standby_t standby = 2'h0;
    irq_qual_t irq_qual = 4'h0;
    pad_drive_t periph = 16'h0000;
    logic [7:0] ext_oe = 8'hFF, ext_val = 8'h00;
    // Design outputs
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    pad_drive_t pad;
    logic [7:0] periph_in, pullup_on, level;
    int fail_count = 0;
    int total_checks = 0;

    // 40 MHz clock
    initial begin
        forever begin
            #12.5 aclk = ~aclk;
        end
    end

    // Pin 7 open-drain so the floating-high case is reachable
    gpio_port_one #(.OPEN_DRAIN_MASK(8'h80)) u_dut (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .standby(standby), .irq_qual(irq_qual), .periph(periph), .periph_in(periph_in),
        .pad_in(level), .pad(pad), .pullup_on(pullup_on));

    // Board model closes the pad loop
    pad_board_model u_board (.aclk(aclk), .pad(pad), .pullup_on(pullup_on),
        .ext_oe(ext_oe), .ext_val(ext_val), .level(level));

    // Compare one byte-wide result
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Write: address and data offered together, each released when taken
    // The response is accepted one edge late, so a waiting response is exercised
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        bit ad;
        bit wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({6'h00, bresp}, {6'h00, er}, "write response");
    endtask : wr

    // Read one register; waits are cut only by the watchdog
    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata[7:0];
        r = rresp;
    endtask : rd

    // Read and compare a mapped register
    task automatic rc(input logic [11:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, exp, what);
        chk({6'h00, r}, {6'h00, `RESP_OKAY}, "read response");
    endtask : rc

    // Pads are looked at mid-cycle, then back on the rising edge
    task automatic pchk(input logic [7:0] oe, input logic [7:0] o, input logic [7:0] pu);
        @(negedge aclk);
        chk(pad.oe, oe, "pad enable");
        chk(pad.out & oe, o, "pad level");
        chk(pullup_on, pu, "pull-up");
        @(posedge aclk);
    endtask : pchk

    // Input synchroniser needs three edges; one spare
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask : settle

    // Reset state of direction and pull-up
    task automatic t_reset();
        rc(A_DIR, `RST_DIR, "direction after reset");
        rc(A_PUL, 8'h00, "pull-up after reset");
        pchk(8'h00, 8'h00, 8'h00);
    endtask : t_reset

    // Mixed directions, readback and the latch view
    task automatic t_ports();
        ext_val <= 8'h96;
        wr(A_DIR, 8'hA5, 4'h1, `RESP_OKAY);
        wr(A_DAT, 8'h3C, 4'h1, `RESP_OKAY);
        pchk(8'hA5, 8'h24, 8'h00);
        settle();
        rc(A_DAT, 8'h36, "mixed read");
        rc(A_VIEW, 8'h3C, "latch view");
        wr(A_DAT, 8'hC3, 4'h1, `RESP_OKAY);
        pchk(8'h25, 8'h01, 8'h00);
        rc(A_VIEW, 8'hC3, "latch after write");
    endtask : t_ports

    // Peripheral drives pin 1, pin 4 is a peripheral input
    task automatic t_periph();
        wr(A_DIR, 8'h00, 4'h1, `RESP_OKAY);
        wr(A_DAT, 8'h00, 4'h1, `RESP_OKAY);
        ext_val <= 8'h10;
        periph.oe <= 8'h02;
        periph.out <= 8'h02;
        pchk(8'h02, 8'h02, 8'h00);
        settle();
        rc(A_DAT, 8'h12, "peripheral pin read");
        chk(periph_in, 8'h12, "peripheral input");
        rc(A_VIEW, 8'h00, "latch under peripheral");
        periph.oe <= 8'h00;
        periph.out <= 8'h00;
    endtask : t_periph

    // Forced and unforced standby, with the two interrupt lines
    task automatic t_standby();
        logic [7:0] d;
        logic [1:0] r;
        wr(A_DIR, 8'hEE, 4'h1, `RESP_OKAY);
        wr(A_DAT, 8'hFF, 4'h1, `RESP_OKAY);
        ext_val <= 8'h11;
        irq_qual.ext_ctrl_en <= 2'h1;
        irq_qual.pin_sel_en <= 2'h3;
        pchk(8'h6E, 8'h6E, 8'h00);
        standby.pin_state_select <= 1'b1;
        standby.stop_or_watch <= 1'b1;
        pchk(8'h00, 8'h00, 8'h00);
        settle();
        chk(periph_in, 8'h01, "blocked inputs");
        rd(A_DAT, d, r);
        chk(d & 8'h11, 8'h01, "blocked read");
        irq_qual.ext_ctrl_en <= 2'h3;
        irq_qual.pin_sel_en <= 2'h1;
        settle();
        chk(periph_in, 8'h01, "half-enabled line");
        standby.pin_state_select <= 1'b0;
        pchk(8'h6E, 8'h6E, 8'h00);
        standby.stop_or_watch <= 1'b0;
        irq_qual <= 4'h0;
    endtask : t_standby

    // Pull-ups against low outputs and the open-drain pin
    task automatic t_pullup();
        wr(A_DIR, 8'h8F, 4'h1, `RESP_OKAY);
        wr(A_DAT, 8'h85, 4'h1, `RESP_OKAY);
        wr(A_PUL, 8'hFF, 4'h1, `RESP_OKAY);
        rc(A_PUL, 8'hFF, "pull-up readback");
        pchk(8'h0F, 8'h05, 8'hF5);
        wr(A_DAT, 8'h05, 4'h1, `RESP_OKAY);
        ext_oe <= 8'h00;
        pchk(8'h8F, 8'h05, 8'h75);
        settle();
        rc(A_DAT, 8'h75, "pulled-up inputs");
        ext_oe <= 8'hFF;
        wr(A_PUL, 8'h00, 4'h1, `RESP_OKAY);
        pchk(8'h8F, 8'h05, 8'h00);
    endtask : t_pullup

    // Refused and strobe-less writes leave registers alone; an unmapped read is refused
    task automatic t_bus();
        logic [7:0] d;
        logic [1:0] r;
        wr(A_VIEW, 8'hFF, 4'h1, `RESP_SLVERR);
        wr(A_BAD, 8'hFF, 4'h1, `RESP_SLVERR);
        wr(A_DIR, 8'hFF, 4'h0, `RESP_OKAY);
        rc(A_DIR, 8'h8F, "direction kept");
        rc(A_VIEW, 8'h05, "latch kept");
        rd(A_BAD, d, r);
        chk(d, 8'h00, "unmapped data");
        chk({6'h00, r}, {6'h00, `RESP_SLVERR}, "unmapped response");
    endtask : t_bus

    // Reset in mid-run must clear a direction that was written before
    task automatic t_rerst();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rc(A_DIR, `RST_DIR, "direction after second reset");
        pchk(8'h00, 8'h00, 8'h00);
    endtask : t_rerst

    // Verdict and end of run
    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_ports();
        t_periph();
        t_standby();
        t_pullup();
        t_bus();
        t_rerst();
        complete_run();
    end

    // Watchdog: the tests need well under 1000 cycles
    initial begin
        #200000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end
endmodule : eight_bit_gpio_port_one_bench
